// *** src/crs_map.svh ***
`ifndef CRS_MAP_SVH
`define CRS_MAP_SVH

// register byte offsets
`define CRS_OFF_CTRL        12'h000
`define CRS_OFF_SOFT_RST    12'h004
`define CRS_OFF_STATUS      12'h008
`define CRS_OFF_IRQ_STAT0   12'h00c
`define CRS_OFF_IRQ_MASK0   12'h010
`define CRS_OFF_IRQ_STAT1   12'h014
`define CRS_OFF_IRQ_MASK1   12'h018
`define CRS_OFF_SUBSYS0     12'h01c
`define CRS_OFF_SUBSYS1     12'h020
`define CRS_OFF_PD          12'h024

// field positions
`define CRS_CTRL_SWRST_BIT  0
`define CRS_ST_SYSRDY0_BIT  0
`define CRS_ST_SYSRDY1_BIT  1
`define CRS_ST_ERR_BIT      2
`define CRS_ST_REFCLK_BIT   3
`define CRS_ST_MACRST_BIT   4
`define CRS_ERR_FIELD_LSB   8
`define CRS_ERR_FIELD_W     8

// key pair for the mac-only reset
`define CRS_MAC_KEY1        32'h0000_4f1c
`define CRS_MAC_KEY2        32'h0000_c1f4

// reset values
`define CRS_IRQ_MASK_RST    32'h0000_0000
`define CRS_PD_RST          2'h0

// times: clock period in ns and figures in own units
`define CRS_CLK_NS          100
`define CRS_GLITCH_US       1
`define CRS_SUB_RST_NS      1200
`define CRS_HW_REL_MS       90
`define CRS_HW_REF_MS       70
`define CRS_SW_REL_MS       10
`define CRS_SW_REF_MS       25
`define CRS_IO_TRI_CYC      4

`endif

// *** src/crs_pkg.sv ***
package crs_pkg;
   typedef enum logic [2:0] {
      CRS_OFF     = 3'b000,
      CRS_TRI     = 3'b001,
      CRS_LATCH   = 3'b010,
      CRS_OSC     = 3'b011,
      CRS_PLL     = 3'b100,
      CRS_WAIT    = 3'b101,
      CRS_RUN     = 3'b110
   } crs_state_t;
endpackage : crs_pkg

// *** src/crs_reset_seq.sv ***
// Design decisions made here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "crs_map.svh"

module crs_reset_seq #(
   parameter int unsigned HW_REL_CYC = (`CRS_HW_REL_MS * 1000000) / `CRS_CLK_NS,
   parameter int unsigned HW_REF_CYC = (`CRS_HW_REF_MS * 1000000) / `CRS_CLK_NS,
   parameter int unsigned SW_REL_CYC = (`CRS_SW_REL_MS * 1000000) / `CRS_CLK_NS,
   parameter int unsigned SW_REF_CYC = (`CRS_SW_REF_MS * 1000000) / `CRS_CLK_NS,
   parameter int unsigned OSC_CYC    = 64,
   parameter int unsigned PLL_CYC    = 64
) (
   // clock, reset, enable
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        clk_en,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // pins and analog status
   input  wire logic        reset_pin_n,
   input  wire logic        power_good,
   input  wire logic        osc_stable,
   input  wire logic        pll_locked,
   input  wire logic [7:0]  strap_pins,
   input  wire logic [7:0]  phy0_err_evt,
   input  wire logic [7:0]  phy1_err_evt,
   // sequencing outputs
   output logic             io_tristate,
   output logic [7:0]       strap_latched,
   output logic             osc_enable,
   output logic             pll_enable,
   output logic             core_rst_n,
   output logic             phy0_rst_n,
   output logic             phy1_rst_n,
   output logic             mac_rst_n,
   output logic             tx_abort,
   output logic             ref_clock_en,
   output logic             phy_sys_irq
);

   localparam int unsigned GLITCH_CYC = (`CRS_GLITCH_US * 1000 + `CRS_CLK_NS - 1) / `CRS_CLK_NS;
   localparam int unsigned SUB_CYC    = `CRS_SUB_RST_NS / `CRS_CLK_NS;

   function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
      hit = (a == off);
   endfunction : hit

   // pin synchronisers
   logic [1:0] rst_sync_q;
   logic [1:0] pg_sync_q;
   logic [1:0] osc_sync_q;
   logic [1:0] pll_sync_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rst_sync_q <= 2'h0;
         pg_sync_q  <= 2'h0;
         osc_sync_q <= 2'h0;
         pll_sync_q <= 2'h0;
      end else if (clk_en) begin
         rst_sync_q <= {rst_sync_q[0], reset_pin_n};
         pg_sync_q  <= {pg_sync_q[0], power_good};
         osc_sync_q <= {osc_sync_q[0], osc_stable};
         pll_sync_q <= {pll_sync_q[0], pll_locked};
      end
   end
   wire pin_n = rst_sync_q[1];
   wire pg    = pg_sync_q[1];

   // deglitch: low must last GLITCH_CYC cycles to count
   logic [7:0] glitch_q;
   logic       pin_low_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         glitch_q  <= 8'h00;
         pin_low_q <= 1'b1;
      end else if (clk_en) begin
         if (pin_n) begin
            glitch_q  <= 8'h00;
            pin_low_q <= 1'b0;
         end else if (glitch_q >= 8'(GLITCH_CYC - 1)) begin
            pin_low_q <= 1'b1;
         end else begin
            glitch_q <= glitch_q + 8'h01;
         end
      end
   end
   wire hw_hold = pin_low_q || !pg;

   // start-up sequencer
   crs_pkg::crs_state_t st_q;
   logic [23:0] seq_cnt_q;
   logic [23:0] ref_cnt_q;
   logic        sw_mode_q;
   logic        sw_start;
   logic [7:0]  strap_q;
   logic        tx_abort_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q       <= crs_pkg::CRS_OFF;
         seq_cnt_q  <= 24'h0;
         ref_cnt_q  <= 24'h0;
         sw_mode_q  <= 1'b0;
         strap_q    <= 8'h00;
         tx_abort_q <= 1'b0;
      end else if (clk_en) begin
         tx_abort_q <= sw_start;
         if (hw_hold) begin
            st_q      <= crs_pkg::CRS_OFF;
            seq_cnt_q <= 24'h0;
            ref_cnt_q <= 24'h0;
            sw_mode_q <= 1'b0;
         end else begin
            if (st_q != crs_pkg::CRS_OFF && ref_cnt_q != 24'hff_ffff)
               ref_cnt_q <= ref_cnt_q + 24'h1;
            if (st_q != crs_pkg::CRS_RUN && st_q != crs_pkg::CRS_OFF)
               seq_cnt_q <= seq_cnt_q + 24'h1;
            case (st_q)
               crs_pkg::CRS_OFF: begin
                  st_q <= crs_pkg::CRS_TRI;
               end
               crs_pkg::CRS_TRI: begin
                  if (seq_cnt_q >= 24'(`CRS_IO_TRI_CYC))
                     st_q <= crs_pkg::CRS_LATCH;
               end
               crs_pkg::CRS_LATCH: begin
                  strap_q <= strap_pins;
                  st_q    <= crs_pkg::CRS_OSC;
               end
               crs_pkg::CRS_OSC: begin
                  if (pg && osc_sync_q[1] && seq_cnt_q >= 24'(OSC_CYC))
                     st_q <= crs_pkg::CRS_PLL;
               end
               crs_pkg::CRS_PLL: begin
                  if (pll_sync_q[1] && seq_cnt_q >= 24'(OSC_CYC + PLL_CYC))
                     st_q <= crs_pkg::CRS_WAIT;
               end
               crs_pkg::CRS_WAIT: begin
                  // fixed release delay hides oscillator variation
                  if (seq_cnt_q >= 24'(sw_mode_q ? SW_REL_CYC - 1 : HW_REL_CYC - 1))
                     st_q <= crs_pkg::CRS_RUN;
               end
               crs_pkg::CRS_RUN: begin
                  if (sw_start) begin
                     st_q      <= crs_pkg::CRS_TRI;
                     seq_cnt_q <= 24'h0;
                     ref_cnt_q <= 24'h0;
                     sw_mode_q <= 1'b1;
                  end
               end
               default: st_q <= crs_pkg::CRS_OFF;
            endcase
         end
      end
   end

   wire running = (st_q == crs_pkg::CRS_RUN);
   assign io_tristate   = (st_q == crs_pkg::CRS_OFF) || (st_q == crs_pkg::CRS_TRI);
   assign strap_latched = strap_q;
   assign osc_enable    = (st_q == crs_pkg::CRS_OSC) || (st_q == crs_pkg::CRS_PLL)
                          || (st_q == crs_pkg::CRS_WAIT) || running;
   assign pll_enable    = (st_q == crs_pkg::CRS_PLL) || (st_q == crs_pkg::CRS_WAIT) || running;
   assign core_rst_n    = running;
   assign tx_abort      = tx_abort_q;
   // ref clock gate opens at the fixed limit counted from when the sequencer leaves CRS_OFF or restarts on soft reset, not from core release
   assign ref_clock_en  = !hw_hold && (st_q != crs_pkg::CRS_OFF) &&
                          (ref_cnt_q >= 24'(sw_mode_q ? SW_REF_CYC - 1 : HW_REF_CYC - 1));

   // apb
   wire wr_acc = psel && penable && pwrite && running;
   wire rd_en  = running;
   assign pready  = 1'b1;
   assign pslverr = 1'b0;

   logic [1:0]  sub_q;
   logic [7:0]  sub_cnt0_q;
   logic [7:0]  sub_cnt1_q;
   logic [1:0]  pd_q;
   logic [31:0] mask0_q;
   logic [31:0] mask1_q;
   logic [7:0]  err0_q;
   logic [7:0]  err1_q;
   logic        key1_seen_q;
   logic [7:0]  mac_cnt_q;
   assign sw_start = wr_acc && hit(paddr, `CRS_OFF_CTRL) && pwdata[`CRS_CTRL_SWRST_BIT];

   // subsystem resets, power-down, masks
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sub_q      <= 2'h0;
         sub_cnt0_q <= 8'h00;
         sub_cnt1_q <= 8'h00;
         pd_q       <= `CRS_PD_RST;
         mask0_q    <= `CRS_IRQ_MASK_RST;
         mask1_q    <= `CRS_IRQ_MASK_RST;
      end else if (clk_en) begin
         if (!running && !sw_mode_q) begin
            sub_q <= 2'h0;
            pd_q  <= `CRS_PD_RST;
         end
         if (sub_q[0]) begin
            sub_cnt0_q <= sub_cnt0_q + 8'h01;
            if (sub_cnt0_q >= 8'(SUB_CYC - 1))
               sub_q[0] <= 1'b0;
         end else if (wr_acc && hit(paddr, `CRS_OFF_SUBSYS0) && pwdata[0]) begin
            sub_q[0]   <= 1'b1;
            sub_cnt0_q <= 8'h00;
         end
         if (sub_q[1]) begin
            sub_cnt1_q <= sub_cnt1_q + 8'h01;
            if (sub_cnt1_q >= 8'(SUB_CYC - 1))
               sub_q[1] <= 1'b0;
         end else if (wr_acc && hit(paddr, `CRS_OFF_SUBSYS1) && pwdata[0]) begin
            sub_q[1]   <= 1'b1;
            sub_cnt1_q <= 8'h00;
         end
         if (wr_acc && hit(paddr, `CRS_OFF_PD))
            pd_q <= pwdata[1:0];
         if (wr_acc && hit(paddr, `CRS_OFF_IRQ_MASK0))
            mask0_q <= pwdata;
         if (wr_acc && hit(paddr, `CRS_OFF_IRQ_MASK1))
            mask1_q <= pwdata;
      end
   end

   // phy resets: second port ignores chip soft reset
   assign phy0_rst_n = running && !sub_q[0];
   assign phy1_rst_n = (running || sw_mode_q) && !sub_q[1] && !hw_hold;

   // mac-only reset via key pair
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         key1_seen_q <= 1'b0;
         mac_cnt_q   <= 8'h00;
      end else if (clk_en) begin
         if (mac_cnt_q != 8'h00)
            mac_cnt_q <= mac_cnt_q - 8'h01;
         if (wr_acc && hit(paddr, `CRS_OFF_SOFT_RST)) begin
            if (key1_seen_q && pwdata == `CRS_MAC_KEY2 && !pd_q[0])
               mac_cnt_q <= 8'(SUB_CYC);
            key1_seen_q <= (pwdata == `CRS_MAC_KEY1);
         end
      end
   end
   assign mac_rst_n = running && (mac_cnt_q == 8'h00);

   // error flags: sticky until hardware reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         err0_q      <= 8'h00;
         err1_q      <= 8'h00;
      end else if (clk_en) begin
         if (hw_hold) begin
            err0_q <= 8'h00;
            err1_q <= 8'h00;
         end else begin
            err0_q <= err0_q | phy0_err_evt;
            err1_q <= err1_q | phy1_err_evt;
         end
      end
   end
   assign phy_sys_irq = |(err0_q & mask0_q[`CRS_ERR_FIELD_LSB +: `CRS_ERR_FIELD_W])
                      | |(err1_q & mask1_q[`CRS_ERR_FIELD_LSB +: `CRS_ERR_FIELD_W]);

   wire err_state = |err0_q || |err1_q;

   // read mux
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0;
      end else if (clk_en) begin
         prdata <= 32'h0;
         if (psel && !penable && !pwrite && rd_en) begin
            if (hit(paddr, `CRS_OFF_STATUS))
               prdata <= {27'h0, mac_cnt_q != 8'h00, ref_clock_en, err_state,
                          phy1_rst_n, phy0_rst_n};
            else if (hit(paddr, `CRS_OFF_IRQ_STAT0))
               prdata <= {16'h0, err0_q, 8'h00};
            else if (hit(paddr, `CRS_OFF_IRQ_STAT1))
               prdata <= {16'h0, err1_q, 8'h00};
            else if (hit(paddr, `CRS_OFF_IRQ_MASK0))
               prdata <= mask0_q;
            else if (hit(paddr, `CRS_OFF_IRQ_MASK1))
               prdata <= mask1_q;
            else if (hit(paddr, `CRS_OFF_SUBSYS0))
               prdata <= {31'h0, sub_q[0]};
            else if (hit(paddr, `CRS_OFF_SUBSYS1))
               prdata <= {31'h0, sub_q[1]};
            else if (hit(paddr, `CRS_OFF_PD))
               prdata <= {30'h0, pd_q};
         end
      end
   end

   unused_a: assert property (@(posedge pclk) disable iff (!presetn)
      (!running) |-> !mac_rst_n) else $error("mac out of reset before release");
   refgate_a: assert property (@(posedge pclk) disable iff (!presetn)
      hw_hold |-> !ref_clock_en) else $error("ref clock during reset");
   tri_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
      hw_hold |=> io_tristate) else $error("io not tristated in reset");
   sub_clear_a: assert property (@(posedge pclk) disable iff (!presetn || !clk_en)
      $rose(sub_q[0]) |-> ##[1:20] !sub_q[0]) else $error("subsystem bit not cleared");
   pll_order_a: assert property (@(posedge pclk) disable iff (!presetn)
      pll_enable |-> osc_enable) else $error("pll before oscillator");
   err_stick_a: assert property (@(posedge pclk) disable iff (!presetn)
      (err_state && !hw_hold) |=> err_state) else $error("error cleared without reset");
   swrst_go_a: assert property (@(posedge pclk) disable iff (!presetn || !clk_en)
      (sw_start && !hw_hold) |=> !core_rst_n && tx_abort) else $error("soft reset ignored");
   irq_mask_a: assert property (@(posedge pclk) disable iff (!presetn)
      (mask0_q == 32'h0 && mask1_q == 32'h0) |-> !phy_sys_irq) else $error("unmasked irq");
   read_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
      (!running && !sw_mode_q) |=> prdata == 32'h0 || running) else $error("read before release");

endmodule : crs_reset_seq
`default_nettype wire

// *** tb/chip_reset_sequencer_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "crs_map.svh"
module chip_reset_sequencer_bench;
   localparam int unsigned HW_REL = 200;
   localparam int unsigned HW_REF = 150;
   localparam int unsigned SW_REL = 100;
   localparam int unsigned SW_REF = 120;
   localparam int unsigned SLACK  = 20;
   logic        pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, cap_q, rd_v;
   logic        reset_pin_n, power_good, osc_stable, pll_locked, io_tristate;
   logic [7:0]  strap_pins, phy0_err_evt, phy1_err_evt, strap_latched;
   logic        osc_enable, pll_enable, core_rst_n, phy0_rst_n, phy1_rst_n;
   logic        mac_rst_n, tx_abort, ref_clock_en, phy_sys_irq, p1lo;
   int          n_mismatch, n_checks, nc, nr;

   crs_reset_seq #(.HW_REL_CYC(HW_REL), .HW_REF_CYC(HW_REF), .SW_REL_CYC(SW_REL),
                   .SW_REF_CYC(SW_REF), .OSC_CYC(16), .PLL_CYC(16)) uut (
      .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .reset_pin_n(reset_pin_n), .power_good(power_good),
      .osc_stable(osc_stable), .pll_locked(pll_locked), .strap_pins(strap_pins),
      .phy0_err_evt(phy0_err_evt), .phy1_err_evt(phy1_err_evt), .io_tristate(io_tristate),
      .strap_latched(strap_latched), .osc_enable(osc_enable), .pll_enable(pll_enable),
      .core_rst_n(core_rst_n), .phy0_rst_n(phy0_rst_n), .phy1_rst_n(phy1_rst_n),
      .mac_rst_n(mac_rst_n), .tx_abort(tx_abort), .ref_clock_en(ref_clock_en),
      .phy_sys_irq(phy_sys_irq));
   crs_host_model host (
      .pclk(pclk), .osc_enable(osc_enable), .pll_enable(pll_enable),
      .reset_pin_n(reset_pin_n), .power_good(power_good), .osc_stable(osc_stable),
      .pll_locked(pll_locked));

   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end
   // read data taken at the access edge
   always @(posedge pclk) if (psel && penable && pready) cap_q <= prdata;

   task automatic close_out();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : close_out
   task automatic chk_w(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask : chk_w
   task automatic chk_b(input string nm, input logic e, input logic g);
      n_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("wrong value %s expected %b seen %b", nm, e, g);
      end
   endtask : chk_b
   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
      @(negedge pclk);
   endtask : cyc
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) n_mismatch++;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(negedge pclk);
      rd_v = cap_q;
   endtask : apb
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr
   task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0000_0000);
      chk_w(nm, e, rd_v);
   endtask : rdc
   task automatic err_evt(input logic [7:0] a, input logic [7:0] b);
      @(posedge pclk);
      phy0_err_evt <= a;
      phy1_err_evt <= b;
      @(posedge pclk);
      phy0_err_evt <= 8'h00;
      phy1_err_evt <= 8'h00;
   endtask : err_evt
   // counts cycles to core release and ref clock gate, watches second phy
   task automatic seq_wait();
      int n;
      n = 0;
      nc = 0;
      nr = 0;
      p1lo = 1'b0;
      while ((nc == 0 || nr == 0) && n < 1000) begin
         @(negedge pclk);
         n++;
         if (nc == 0 && core_rst_n === 1'b1) nc = n;
         if (nr == 0 && ref_clock_en === 1'b1) nr = n;
         if (phy1_rst_n !== 1'b1) p1lo = 1'b1;
      end
   endtask : seq_wait

   initial begin
      #(20000 * 100);
      n_mismatch++;
      close_out();
   end

   initial begin
      presetn = 1'b0;
      clk_en = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      strap_pins = 8'ha5;
      phy0_err_evt = 8'h00;
      phy1_err_evt = 8'h00;
      n_mismatch = 0;
      n_checks = 0;
      cyc(10);
      chk_b("tri rst", 1'b1, io_tristate);
      chk_b("core rst", 1'b0, core_rst_n);
      @(posedge pclk);
      presetn <= 1'b1;
      cyc(30);
      chk_b("core nopg", 1'b0, core_rst_n);
      chk_b("osc nopg", 1'b0, osc_enable);
      rdc("early rd", `CRS_OFF_STATUS, 32'h0000_0000);
      wr(`CRS_OFF_IRQ_MASK0, 32'h0000_ff00);
      host.set_power(1'b1);
      seq_wait();
      chk_b("hw rel", 1'b1, nc > 0 && nc <= HW_REL + SLACK);
      chk_b("hw ref", 1'b1, nr > 0 && nr <= HW_REF + SLACK);
      chk_w("straps", 32'h0000_00a5, {24'h0, strap_latched});
      chk_b("tri run", 1'b0, io_tristate);
      rdc("dropped", `CRS_OFF_IRQ_MASK0, `CRS_IRQ_MASK_RST);
      rdc("status", `CRS_OFF_STATUS, 32'h0000_000b);
      rdc("unmapped", 12'h3fc, 32'h0000_0000);
      chk_b("slverr", 1'b0, pslverr);
      host.set_pin(1'b0);
      repeat (5) @(posedge pclk);
      host.set_pin(1'b1);
      cyc(20);
      chk_b("glitch", 1'b1, core_rst_n);
      wr(`CRS_OFF_CTRL, 32'h0000_0001);
      chk_b("abort", 1'b1, tx_abort);
      cyc(1);
      chk_b("sw core", 1'b0, core_rst_n);
      seq_wait();
      chk_b("sw rel", 1'b1, nc > 0 && nc <= SW_REL + SLACK);
      chk_b("sw ref", 1'b1, nr > 0 && nr <= SW_REF + SLACK);
      chk_b("second_port", 1'b0, p1lo);
      wr(`CRS_OFF_IRQ_MASK0, 32'h0000_ff00);
      for (int i = 0; i < 2; i++) begin
         wr(`CRS_OFF_SUBSYS0 + 12'(4 * i), 32'h0000_0001);
         rdc("sub set", `CRS_OFF_SUBSYS0 + 12'(4 * i), 32'h0000_0001);
         chk_b("sub rst", 1'b0, (i == 0) ? phy0_rst_n : phy1_rst_n);
         rdc("sub mask", `CRS_OFF_IRQ_MASK0, 32'h0000_ff00);
         cyc(20);
         rdc("sub clr", `CRS_OFF_SUBSYS0 + 12'(4 * i), 32'h0000_0000);
         chk_b("sub rel", 1'b1, (i == 0) ? phy0_rst_n : phy1_rst_n);
      end
      for (int pd = 0; pd < 2; pd++) begin
         wr(`CRS_OFF_PD, 32'(1 - pd));
         wr(`CRS_OFF_SOFT_RST, `CRS_MAC_KEY1);
         wr(`CRS_OFF_SOFT_RST, `CRS_MAC_KEY2);
         cyc(1);
         chk_b("mac rst", 1'(pd), ~mac_rst_n);
         chk_b("mac phy", 1'b1, phy0_rst_n & phy1_rst_n);
         rdc("mac stat", `CRS_OFF_STATUS, 32'h0000_000b | 32'(pd << 4));
         cyc(20);
         chk_b("mac end", 1'b1, mac_rst_n);
      end
      // clock enable low must freeze the self-clearing pulse
      wr(`CRS_OFF_SUBSYS0, 32'h0000_0001);
      @(posedge pclk);
      clk_en <= 1'b0;
      cyc(30);
      chk_b("frz sub", 1'b0, phy0_rst_n);
      @(posedge pclk);
      clk_en <= 1'b1;
      cyc(20);
      chk_b("frz end", 1'b1, phy0_rst_n);
      wr(`CRS_OFF_IRQ_MASK0, 32'h0000_0000);
      err_evt(8'h08, 8'h01);
      rdc("irq st0", `CRS_OFF_IRQ_STAT0, 32'h0000_0800);
      rdc("irq st1", `CRS_OFF_IRQ_STAT1, 32'h0000_0100);
      chk_b("irq off", 1'b0, phy_sys_irq);
      wr(`CRS_OFF_IRQ_MASK0, 32'h0000_0800);
      cyc(1);
      chk_b("irq on", 1'b1, phy_sys_irq);
      cyc(30);
      rdc("err hold", `CRS_OFF_STATUS, 32'h0000_000f);
      host.set_pin(1'b0);
      strap_pins <= 8'h3c;
      cyc(110);
      chk_b("pin core", 1'b0, core_rst_n);
      chk_b("pin ref", 1'b0, ref_clock_en);
      chk_b("pin tri", 1'b1, io_tristate);
      host.set_pin(1'b1);
      seq_wait();
      chk_b("pin rel", 1'b1, nc > 0 && nc <= HW_REL + SLACK);
      chk_w("straps2", 32'h0000_003c, {24'h0, strap_latched});
      rdc("err clr", `CRS_OFF_IRQ_STAT0, 32'h0000_0000);
      rdc("st clr", `CRS_OFF_STATUS, 32'h0000_000b);
      close_out();
   end
endmodule : chip_reset_sequencer_bench
`default_nettype wire

// *** tb/crs_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module crs_host_model (
   // clock
   input  wire logic pclk,
   // enables from the device
   input  wire logic osc_enable,
   input  wire logic pll_enable,
   // pin and analog levels
   output logic      reset_pin_n,
   output logic      power_good,
   output logic      osc_stable,
   output logic      pll_locked
);
   initial begin
      reset_pin_n = 1'b1;
      power_good  = 1'b0;
   end
   task automatic set_pin(input logic v);
      @(posedge pclk);
      reset_pin_n <= v;
   endtask : set_pin
   task automatic set_power(input logic v);
      @(posedge pclk);
      power_good <= v;
   endtask : set_power
   // crystal settles only once enabled, pll locks only once enabled
   always_ff @(posedge pclk) begin
      osc_stable <= osc_enable;
      pll_locked <= pll_enable;
   end
endmodule : crs_host_model
`default_nettype wire
